// ### rdd_pkg.sv
// Package for the remap entry destination decoder: offsets, fields, modes, result carrier
package rdd_pkg;

    // Register byte offsets
    localparam logic [11:0] ADDR_ENTRY_LO = 12'h000;
    localparam logic [11:0] ADDR_ENTRY_HI = 12'h004;
    localparam logic [11:0] ADDR_TARGET = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00C;

    // Entry field positions
    localparam int PRESENT_BIT = 0;
    localparam int VEC_LSB = 16;
    localparam int VEC_W = 8;
    localparam int RSVD_LSB = 24;
    localparam int RSVD_W = 8;
    localparam int DST_LSB = 32;
    localparam int DST_W = 32;
    localparam int HI_NIB_LSB = 44;
    localparam int LO_NIB_LSB = 40;
    localparam int NIB_W = 4;
    localparam int LEG_DST_LSB = 40;
    localparam int LEG_DST_W = 8;
    localparam int LEG_RSVD_HI_LSB = 48;
    localparam int LEG_RSVD_HI_W = 16;
    localparam int LEG_RSVD_LO_LSB = 32;
    localparam int LEG_RSVD_LO_W = 8;

    // Status register field positions
    localparam int ST_VALID_BIT = 0;
    localparam int ST_RSVD_BIT = 1;
    localparam int ST_MODE_LSB = 4;
    localparam int ST_VEC_LSB = 8;

    // Reset values
    localparam logic [63:0] ENTRY_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
    localparam logic [23:0] LEG_PAD = 24'h00_0000;

    typedef enum logic [1:0] {
        RDD_MODE_CLUSTER = 2'b00,
        RDD_MODE_FLAT = 2'b01,
        RDD_MODE_PHYS = 2'b10,
        RDD_MODE_WIDE = 2'b11
    } rdd_mode_t;

    typedef struct packed {
        logic valid;
        logic rsvd_err;
        logic [7:0] vector;
        logic [31:0] cpu_target_id;
    } rdd_result_t;

    localparam rdd_result_t RESULT_RST = '{valid: 1'b0, rsvd_err: 1'b0, vector: 8'h00, cpu_target_id: 32'h0000_0000};

endpackage

// ### rdd_decode.sv
// Remap entry destination decoder with APB register access
//
// Register access over APB and the placing of the registers were decided locally.
`timescale 1ns/10ps
// What this block does
// [R1] Entry bits 63:32 carry the target processor identifier field.
// [R2] Target field is ignored unless the entry's present flag is set.
// [R3] Legacy cluster mode: upper nibble from bits 47:44, lower from 43:40.
// [R4] Legacy flat mode: full 8-bit target from bits 47:40.
// [R5] Software writes zero to bits 63:48 and 39:32 in legacy modes.
// [R6] Wide physical mode: all 32 bits 63:32 form the target identifier.
// [R7] Bits 31:24 must be zero; checked only when present flag set.
// [R8] Vector comes from bits 23:16, used only when present flag set.
// [R9] Layout chosen by a stable platform addressing-mode input.
module rdd_decode (
    input wire logic clk,
    input wire logic nrst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [1:0] addr_mode,
    output rdd_pkg::rdd_result_t decode_out
);

    // Decode one entry under one addressing layout
    function automatic rdd_pkg::rdd_result_t decode_entry(input logic [63:0] e, input rdd_pkg::rdd_mode_t m);
        rdd_pkg::rdd_result_t r;
        r = rdd_pkg::RESULT_RST;
        if (e[rdd_pkg::PRESENT_BIT]) begin // [R2]
            r.valid = 1'b1;
            r.vector = e[rdd_pkg::VEC_LSB +: rdd_pkg::VEC_W]; // [R8]
            r.rsvd_err = |e[rdd_pkg::RSVD_LSB +: rdd_pkg::RSVD_W]; // [R7]
            case (m) // [R9]
                rdd_pkg::RDD_MODE_CLUSTER: begin
                    r.cpu_target_id = {rdd_pkg::LEG_PAD, e[rdd_pkg::HI_NIB_LSB +: rdd_pkg::NIB_W],
                        e[rdd_pkg::LO_NIB_LSB +: rdd_pkg::NIB_W]}; // [R3]
                end
                rdd_pkg::RDD_MODE_FLAT, rdd_pkg::RDD_MODE_PHYS: begin
                    r.cpu_target_id = {rdd_pkg::LEG_PAD, e[rdd_pkg::LEG_DST_LSB +: rdd_pkg::LEG_DST_W]}; // [R4]
                end
                default: begin
                    r.cpu_target_id = e[rdd_pkg::DST_LSB +: rdd_pkg::DST_W]; // [R1] [R6]
                end
            endcase
            if (m != rdd_pkg::RDD_MODE_WIDE) begin
                // Flag legacy bits that software left nonzero
                r.rsvd_err = r.rsvd_err | (|e[rdd_pkg::LEG_RSVD_HI_LSB +: rdd_pkg::LEG_RSVD_HI_W])
                    | (|e[rdd_pkg::LEG_RSVD_LO_LSB +: rdd_pkg::LEG_RSVD_LO_W]); // [R5]
            end
        end
        return r;
    endfunction

    logic [63:0] entry_reg, entry_next;
    logic [1:0] sync1_reg, sync2_reg, sync3_reg;
    rdd_pkg::rdd_mode_t mode_reg, mode_next;
    rdd_pkg::rdd_result_t result_reg, result_next;
    logic [31:0] prdata_reg, prdata_next;
    logic pslverr_reg, pslverr_next;
    logic setup, wr_access, mapped;

    assign setup = psel && !penable;
    assign wr_access = psel && penable && pwrite;
    assign mapped = (paddr == rdd_pkg::ADDR_ENTRY_LO) || (paddr == rdd_pkg::ADDR_ENTRY_HI)
        || (paddr == rdd_pkg::ADDR_TARGET) || (paddr == rdd_pkg::ADDR_STATUS);

    // Entry storage and register read path
    always_comb begin
        entry_next = entry_reg;
        prdata_next = prdata_reg;
        pslverr_next = pslverr_reg;
        if (wr_access && paddr == rdd_pkg::ADDR_ENTRY_LO) begin
            entry_next[31:0] = pwdata;
        end
        if (wr_access && paddr == rdd_pkg::ADDR_ENTRY_HI) begin
            entry_next[63:32] = pwdata;
        end
        if (setup) begin
            pslverr_next = !mapped;
            prdata_next = rdd_pkg::WORD_ZERO;
            if (!pwrite) begin
                case (paddr)
                    rdd_pkg::ADDR_ENTRY_LO: prdata_next = entry_reg[31:0];
                    rdd_pkg::ADDR_ENTRY_HI: prdata_next = entry_reg[63:32];
                    rdd_pkg::ADDR_TARGET: prdata_next = result_reg.cpu_target_id;
                    rdd_pkg::ADDR_STATUS: begin
                        prdata_next[rdd_pkg::ST_VALID_BIT] = result_reg.valid;
                        prdata_next[rdd_pkg::ST_RSVD_BIT] = result_reg.rsvd_err;
                        prdata_next[rdd_pkg::ST_MODE_LSB +: 2] = mode_reg;
                        prdata_next[rdd_pkg::ST_VEC_LSB +: rdd_pkg::VEC_W] = result_reg.vector;
                    end
                    default: prdata_next = rdd_pkg::WORD_ZERO;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            entry_reg <= rdd_pkg::ENTRY_RST;
            prdata_reg <= rdd_pkg::WORD_ZERO;
            pslverr_reg <= 1'b0;
        end else begin
            entry_reg <= entry_next;
            prdata_reg <= prdata_next;
            pslverr_reg <= pslverr_next;
        end
    end

    // Mode pin synchroniser; change accepted when stages two and three agree
    always_comb begin
        mode_next = mode_reg;
        if (sync2_reg == sync3_reg) begin
            mode_next = rdd_pkg::rdd_mode_t'(sync3_reg); // [R9]
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sync1_reg <= 2'h0;
            sync2_reg <= 2'h0;
            sync3_reg <= 2'h0;
            mode_reg <= rdd_pkg::RDD_MODE_CLUSTER;
        end else begin
            sync1_reg <= addr_mode;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
            mode_reg <= mode_next;
        end
    end

    // Decode result register
    always_comb begin
        result_next = decode_entry(entry_reg, mode_reg);
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            result_reg <= rdd_pkg::RESULT_RST;
        end else begin
            result_reg <= result_next;
        end
    end

    assign prdata = prdata_reg;
    assign pready = 1'b1;
    assign pslverr = pslverr_reg & psel & penable;
    assign decode_out = result_reg;

    // Checks
    logic [7:0] chk_vec, chk_rsvd, chk_flat;
    logic [3:0] chk_hi, chk_lo;
    logic [31:0] chk_dst;
    logic [15:0] chk_leg_hi;
    logic [7:0] chk_leg_lo;
    assign chk_vec = entry_reg[rdd_pkg::VEC_LSB +: rdd_pkg::VEC_W];
    assign chk_rsvd = entry_reg[rdd_pkg::RSVD_LSB +: rdd_pkg::RSVD_W];
    assign chk_flat = entry_reg[rdd_pkg::LEG_DST_LSB +: rdd_pkg::LEG_DST_W];
    assign chk_hi = entry_reg[rdd_pkg::HI_NIB_LSB +: rdd_pkg::NIB_W];
    assign chk_lo = entry_reg[rdd_pkg::LO_NIB_LSB +: rdd_pkg::NIB_W];
    assign chk_dst = entry_reg[rdd_pkg::DST_LSB +: rdd_pkg::DST_W];
    assign chk_leg_hi = entry_reg[rdd_pkg::LEG_RSVD_HI_LSB +: rdd_pkg::LEG_RSVD_HI_W];
    assign chk_leg_lo = entry_reg[rdd_pkg::LEG_RSVD_LO_LSB +: rdd_pkg::LEG_RSVD_LO_W];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    a_absent_entry_quiet: assert property (!entry_reg[rdd_pkg::PRESENT_BIT] |=> // [R2]
        !decode_out.valid && decode_out.cpu_target_id == 32'h0000_0000 && !decode_out.rsvd_err)
        else $error("Absent entry produced a decode");
    a_vector_taken: assert property (entry_reg[rdd_pkg::PRESENT_BIT] |=> // [R8]
        decode_out.valid && decode_out.vector == $past(chk_vec))
        else $error("Vector not taken from entry");
    a_cluster_nibbles: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && mode_reg == rdd_pkg::RDD_MODE_CLUSTER |=> // [R3]
        decode_out.cpu_target_id == {24'h00_0000, $past(chk_hi), $past(chk_lo)})
        else $error("Cluster target wrong");
    a_flat_byte: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && mode_reg == rdd_pkg::RDD_MODE_FLAT |=> // [R4]
        decode_out.cpu_target_id == {24'h00_0000, $past(chk_flat)})
        else $error("Flat target wrong");
    a_wide_target: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && mode_reg == rdd_pkg::RDD_MODE_WIDE |=> // [R6] [R1]
        decode_out.cpu_target_id == $past(chk_dst))
        else $error("Wide target wrong");
    a_rsvd_flagged: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && chk_rsvd != 8'h00 |=> // [R7]
        decode_out.rsvd_err)
        else $error("Nonzero reserved byte not flagged");
    a_mode_settled: assert property ((mode_reg != $past(mode_reg)) |-> // [R9]
        $past(sync2_reg) == $past(sync3_reg) && mode_reg == $past(sync3_reg))
        else $error("Mode changed without agreement");
    a_mode_follows_pin: assert property ((addr_mode == 2'h2)[*6] |-> mode_reg == rdd_pkg::RDD_MODE_PHYS) // [R9]
        else $error("Mode did not follow stable pin");
    a_entry_write: assert property (wr_access && paddr == rdd_pkg::ADDR_ENTRY_HI |=> // [R1]
        chk_dst == $past(pwdata) ##1 (!entry_reg[rdd_pkg::PRESENT_BIT] || mode_reg != rdd_pkg::RDD_MODE_WIDE
        || decode_out.cpu_target_id == $past(chk_dst)))
        else $error("Target word write not decoded");
    a_phys_byte: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && mode_reg == rdd_pkg::RDD_MODE_PHYS |=> // [R4]
        decode_out.cpu_target_id == {24'h00_0000, $past(chk_flat)})
        else $error("Physical target wrong");
    a_legacy_rsvd_flag: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && // [R5]
        mode_reg != rdd_pkg::RDD_MODE_WIDE && (chk_leg_hi != 16'h0000 || chk_leg_lo != 8'h00) |=>
        decode_out.rsvd_err)
        else $error("Nonzero legacy bits not flagged");
    a_wide_rsvd_only: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && // [R6]
        mode_reg == rdd_pkg::RDD_MODE_WIDE && chk_rsvd == 8'h00 |=> !decode_out.rsvd_err)
        else $error("Wide target bits flagged as reserved");
    a_rsvd_clean: assert property (entry_reg[rdd_pkg::PRESENT_BIT] && chk_rsvd == 8'h00 && // [R7]
        mode_reg != rdd_pkg::RDD_MODE_WIDE && chk_leg_hi == 16'h0000 && chk_leg_lo == 8'h00 |=>
        !decode_out.rsvd_err)
        else $error("Clean entry flagged");
    a_absent_vector: assert property (!entry_reg[rdd_pkg::PRESENT_BIT] |=> decode_out.vector == 8'h00) // [R8]
        else $error("Absent entry passed a vector");
    a_result_stable: assert property ($stable(entry_reg) && $stable(mode_reg) |=> $stable(decode_out)) // [R9]
        else $error("Decode changed with no cause");
    a_target_readback: assert property (setup && !pwrite && paddr == rdd_pkg::ADDR_TARGET |=> // [R1]
        prdata == $past(result_reg.cpu_target_id))
        else $error("Target read wrong");
    a_status_mode: assert property (setup && !pwrite && paddr == rdd_pkg::ADDR_STATUS |=> // [R9]
        prdata[rdd_pkg::ST_MODE_LSB +: 2] == $past(mode_reg))
        else $error("Status mode wrong");

endmodule // rdd_decode

// ### rdd_fabric.sv
// Partner model: platform mode pin and delivery-side capture
`timescale 1ns/10ps
module rdd_fabric (
    input wire logic clk,
    input wire rdd_pkg::rdd_result_t decode_out,
    output logic [1:0] addr_mode
);
    rdd_pkg::rdd_result_t taken;
    initial addr_mode = 2'b00;
    // Mode changes only between decodes, then held
    task automatic set_mode(input logic [1:0] m);
        @(posedge clk);
        addr_mode <= m;
    endtask
    // Fabric only acts on a present entry
    always @(posedge clk) begin
        if (decode_out.valid === 1'b1) begin
            taken <= decode_out;
        end
    end
endmodule // rdd_fabric

// ### rdd_decode_tb.sv
// Testbench for the remap entry destination decoder
`timescale 1ns/10ps
module rdd_decode_tb;
    logic clk, nrst, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [1:0] addr_mode;
    rdd_pkg::rdd_result_t decode_out;
    int error_cnt = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] hi_v [4] = '{32'h0000_5C00, 32'h0000_5C00, 32'h0000_5C00, 32'h8123_45C6};
    logic [31:0] tg_v [4] = '{32'h0000_005C, 32'h0000_005C, 32'h0000_005C, 32'h8123_45C6};

    rdd_decode rdd_decode_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .addr_mode(addr_mode), .decode_out(decode_out));
    rdd_fabric rdd_fabric_inst (.clk(clk), .decode_out(decode_out), .addr_mode(addr_mode));

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            close_out();
        end
    end

    initial begin
        nrst = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        chk(decode_out, 64'h0);
        apb(1'b0, rdd_pkg::ADDR_ENTRY_LO, 32'h0, rd, er);
        chk(rd, 64'h0);
        $display("test reset done");
        for (int m = 0; m < 4; m++) begin
            rdd_fabric_inst.set_mode(m[1:0]);
            repeat (6) @(posedge clk);
            apb(1'b1, rdd_pkg::ADDR_ENTRY_LO, 32'h00A7_0001, rd, er);
            apb(1'b1, rdd_pkg::ADDR_ENTRY_HI, hi_v[m], rd, er);
            repeat (2) @(posedge clk);
            chk(decode_out, {1'b1, 1'b0, 8'hA7, tg_v[m]});
            apb(1'b0, rdd_pkg::ADDR_STATUS, 32'h0, rd, er);
            chk(rd, {16'h0, 8'hA7, 2'b00, m[1:0], 4'h1});
            $display("test mode %0d done", m);
        end
        apb(1'b1, rdd_pkg::ADDR_ENTRY_LO, 32'h00A7_0000, rd, er);
        repeat (2) @(posedge clk);
        chk(decode_out, 64'h0);
        apb(1'b1, rdd_pkg::ADDR_ENTRY_LO, 32'hFFA7_0000, rd, er);
        repeat (2) @(posedge clk);
        chk(decode_out.rsvd_err, 64'h0);
        apb(1'b1, rdd_pkg::ADDR_ENTRY_LO, 32'hFFA7_0001, rd, er);
        repeat (2) @(posedge clk);
        chk(decode_out.rsvd_err, 64'h1);
        $display("test present and reserved done");
        apb(1'b1, rdd_pkg::ADDR_TARGET, 32'hDEAD_BEEF, rd, er);
        apb(1'b0, rdd_pkg::ADDR_TARGET, 32'h0, rd, er);
        chk(rd, 64'h8123_45C6);
        apb(1'b0, 12'h010, 32'h0, rd, er);
        chk({er, rd}, {1'b1, 32'h0});
        chk(rdd_fabric_inst.taken, {1'b1, 1'b1, 8'hA7, 32'h8123_45C6});
        $display("test access kinds done");
        rdd_fabric_inst.set_mode(2'b00);
        apb(1'b1, rdd_pkg::ADDR_ENTRY_LO, 32'h00A7_0001, rd, er);
        repeat (6) @(posedge clk);
        chk(decode_out, {1'b1, 1'b1, 8'hA7, 32'h0000_0045});
        $display("test legacy reserved done");
        close_out();
    end
endmodule // rdd_decode_tb
